// ===== verilog/sis_top.sv
`timescale 1ns/1ps
`default_nettype none
module sis_top
    import sis_pkg::*;
#(
    parameter int PU_CYC     = SIS_PU_CYC,
    parameter int SR_CYC     = SIS_SR_CYC,
    parameter int MEAS_N_CYC = SIS_MEAS_N_CYC,
    parameter int MEAS_L_CYC = SIS_MEAS_L_CYC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        resetn_i,
    input  wire logic        scl_clk_i,
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             scl_o,
    output logic             scl_oe_n_o,
    output logic             sda_o,
    output logic             sda_oe_n_o,
    input  wire logic [15:0] temp_data_i,
    input  wire logic [15:0] hum_data_i,
    output logic             meas_start_o,
    output logic             meas_low_power_o,
    output logic             calib_reload_o,
    output logic             idle_o,
    output logic             measuring_o
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (PU_CYC < 1 || SR_CYC < 1 || MEAS_N_CYC < 1 || MEAS_L_CYC < 1) begin : g_chk_lo
        $error("sis_top: timing counts must be at least one cycle");
    end
    if (PU_CYC >= (1 << SIS_TMR_W) || SR_CYC >= (1 << SIS_TMR_W) ||
        MEAS_N_CYC >= (1 << SIS_TMR_W) || MEAS_L_CYC >= (1 << SIS_TMR_W)) begin : g_chk_hi
        $error("sis_top: timing count exceeds timer width");
    end

    localparam logic [SIS_TMR_W-1:0] PU_LIM = SIS_TMR_W'(PU_CYC - 1);
    localparam logic [SIS_TMR_W-1:0] SR_LIM = SIS_TMR_W'(SR_CYC - 1);
    localparam logic [SIS_TMR_W-1:0] MN_LIM = SIS_TMR_W'(MEAS_N_CYC - 1);
    localparam logic [SIS_TMR_W-1:0] ML_LIM = SIS_TMR_W'(MEAS_L_CYC - 1);

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic [7:0] sis_crc(input logic [15:0] w);
        logic [7:0] c;
        c = SIS_CRC_INIT;
        for (int b = 15; b >= 0; b--) begin
            c = (c[7] ^ w[b]) ? ({c[6:0], 1'b0} ^ SIS_CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction : sis_crc

    function automatic logic [7:0] sis_tx_byte(input logic [2:0] i, input logic [15:0] w0,
                                               input logic [15:0] w1);
        case (i)
            3'h0:    return w0[15:8];
            3'h1:    return w0[7:0];
            3'h2:    return sis_crc(w0);
            3'h3:    return w1[15:8];
            3'h4:    return w1[7:0];
            default: return sis_crc(w1);
        endcase
    endfunction : sis_tx_byte

    // ************************************************************
    // Link domain: SDA sampled on each SCL rise
    // ************************************************************
    typedef struct packed {
        logic bit_v;
        logic tog;
    } sis_link_type;

    sis_link_type lq, ld;

    always_comb begin
        ld       = lq;
        ld.bit_v = sda_i;
        ld.tog   = ~lq.tog;
    end

    // Bit stays stable until the next SCL rise, long after the toggle has crossed
    always_ff @(posedge scl_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lq <= '0;
        end else begin
            lq <= ld;
        end
    end

    // ************************************************************
    // System domain
    // ************************************************************
    typedef struct packed {
        sis_state_type        state;
        sis_phase_type        phase;
        logic [SIS_TMR_W-1:0] timer;
        logic [7:0]           shift;
        logic [3:0]           cnt;
        logic [2:0]           bytei;
        logic                 rw;
        logic [7:0]           cmd_hi;
        logic                 stretch;
        logic                 lp;
        logic [15:0]          res0;
        logic [15:0]          res1;
        logic                 rh_first;
        logic                 sda_oen;
        logic                 scl_oen;
        logic                 scl_s1;
        logic                 scl_s2;
        logic                 scl_d;
        logic                 sda_s1;
        logic                 sda_s2;
        logic                 sda_d;
        logic                 tog_s1;
        logic                 tog_s2;
        logic                 tog_s3;
        logic                 start_p;
        logic                 reload_p;
    } sis_sys_type;

    localparam sis_sys_type SYS_RST = '{
        state: ST_WAIT, phase: PH_BOOT, sda_oen: 1'b1, scl_oen: 1'b1,
        scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
        sda_d: 1'b1, default: '0};

    sis_sys_type q, d;

    logic                 scl_fall;
    logic                 start_c;
    logic                 stop_c;
    logic                 bit_ev;
    logic                 hdr_ok;
    logic                 phase_done;
    logic [SIS_TMR_W-1:0] lim;
    logic [15:0]          cmd;
    logic [7:0]           nb;

    always_comb begin
        d          = q;
        d.start_p  = 1'b0;
        d.reload_p = 1'b0;
        d.scl_s1   = scl_i;
        d.scl_s2   = q.scl_s1;
        d.scl_d    = q.scl_s2;
        d.sda_s1   = sda_i;
        d.sda_s2   = q.sda_s1;
        d.sda_d    = q.sda_s2;
        d.tog_s1   = lq.tog;
        d.tog_s2   = q.tog_s1;
        d.tog_s3   = q.tog_s2;

        scl_fall = q.scl_d & ~q.scl_s2;
        start_c  = q.scl_s2 & q.scl_d & q.sda_d & ~q.sda_s2;
        stop_c   = q.scl_s2 & q.scl_d & ~q.sda_d & q.sda_s2;
        bit_ev   = q.tog_s2 ^ q.tog_s3;
        cmd      = {q.cmd_hi, q.shift};
        nb       = sis_tx_byte(q.bytei, q.res0, q.res1);

        // Headers acknowledged only when idle or for a stretching read
        hdr_ok = (q.shift[7:1] == SIS_HDR_ADDR[7:1]) &&
                 ((q.phase == PH_IDLE) ||
                  (q.phase == PH_MEAS && q.stretch && q.shift[0]));

        // ********************************************************
        // Phase timer
        // ********************************************************
        case (q.phase)
            PH_BOOT:  lim = PU_LIM;
            PH_RESET: lim = SR_LIM;
            PH_MEAS:  lim = q.lp ? ML_LIM : MN_LIM;
            default:  lim = '0;
        endcase
        phase_done = (q.phase != PH_IDLE) && (q.timer == lim);
        if (q.phase != PH_IDLE) begin
            d.timer = q.timer + 1'b1;
        end
        if (phase_done) begin
            d.phase = PH_IDLE;
            d.timer = '0;
            if (q.phase == PH_MEAS) begin
                d.res0 = q.rh_first ? hum_data_i : temp_data_i;
                d.res1 = q.rh_first ? temp_data_i : hum_data_i;
            end
        end

        // ********************************************************
        // Byte engine, driven by synchronised SCL edges
        // ********************************************************
        case (q.state)
            ST_WAIT: begin
            end
            ST_ADDR, ST_WRX: begin
                if (bit_ev) begin
                    d.shift = {q.shift[6:0], lq.bit_v};
                    d.cnt   = q.cnt + 4'h1;
                end
                if (q.cnt == 4'h8 && scl_fall) begin
                    d.cnt = '0;
                    if (q.state == ST_WRX) begin
                        d.sda_oen = 1'b0;
                        d.state   = ST_WACK;
                        if (q.bytei == 3'h0) begin
                            d.cmd_hi = q.shift;
                        end
                    end else if (hdr_ok) begin
                        d.rw      = q.shift[0];
                        d.bytei   = '0;
                        d.sda_oen = 1'b0;
                        d.state   = ST_AACK;
                    end else begin
                        d.state = ST_WAIT;
                    end
                end
            end
            ST_AACK: begin
                if (scl_fall) begin
                    d.sda_oen = 1'b1;
                    if (!q.rw) begin
                        d.state = ST_WRX;
                    end else if (q.phase == PH_MEAS) begin
                        d.scl_oen = 1'b0;
                        d.state   = ST_STRETCH;
                    end else begin
                        d.shift   = nb;
                        d.sda_oen = nb[7];
                        d.state   = ST_TX;
                    end
                end
            end
            ST_STRETCH: begin
                // Results are latched on the same edge that sets the phase to idle
                if (q.phase == PH_IDLE) begin
                    d.shift   = nb;
                    d.sda_oen = nb[7];
                    d.scl_oen = 1'b1;
                    d.state   = ST_TX;
                end
            end
            ST_TX: begin
                if (scl_fall) begin
                    d.cnt = q.cnt + 4'h1;
                    if (q.cnt == 4'h7) begin
                        d.cnt     = '0;
                        d.sda_oen = 1'b1;
                        d.state   = ST_TACK;
                    end else begin
                        d.shift   = {q.shift[6:0], 1'b0};
                        d.sda_oen = q.shift[6];
                    end
                end
            end
            ST_TACK: begin
                // A missing acknowledge ends the read
                if (bit_ev) begin
                    if (!lq.bit_v && q.bytei != SIS_LAST_BYTE) begin
                        d.bytei = q.bytei + 3'h1;
                        d.state = ST_TNEXT;
                    end else begin
                        d.state = ST_WAIT;
                    end
                end
            end
            ST_TNEXT: begin
                if (scl_fall) begin
                    d.shift   = nb;
                    d.sda_oen = nb[7];
                    d.state   = ST_TX;
                end
            end
            ST_WACK: begin
                if (scl_fall) begin
                    d.sda_oen = 1'b1;
                    d.bytei   = 3'h1;
                    d.state   = ST_WRX;
                    if (q.bytei == 3'h1) begin
                        d.state = ST_WAIT;
                        if (q.phase == PH_IDLE) begin
                            case (cmd)
                                SIS_CMD_SRST: begin
                                    d.phase    = PH_RESET;
                                    d.timer    = '0;
                                    d.reload_p = 1'b1;
                                    d.res0     = '0;
                                    d.res1     = '0;
                                end
                                SIS_CMD_N_CS_T, SIS_CMD_N_CS_RH, SIS_CMD_N_T, SIS_CMD_N_RH,
                                SIS_CMD_L_CS_T, SIS_CMD_L_CS_RH, SIS_CMD_L_T,
                                SIS_CMD_L_RH: begin
                                    d.phase    = PH_MEAS;
                                    d.timer    = '0;
                                    d.start_p  = 1'b1;
                                    d.lp       = (cmd[15:12] == 4'h6) || (cmd[15:12] == 4'h4);
                                    d.stretch  = (cmd == SIS_CMD_N_CS_T) || (cmd == SIS_CMD_N_CS_RH)
                                              || (cmd == SIS_CMD_L_CS_T) || (cmd == SIS_CMD_L_CS_RH);
                                    d.rh_first = (cmd == SIS_CMD_N_CS_RH) || (cmd == SIS_CMD_N_RH)
                                              || (cmd == SIS_CMD_L_CS_RH) || (cmd == SIS_CMD_L_RH);
                                end
                                default: begin
                                end
                            endcase
                        end
                    end
                end
            end
            default: begin
                d.state = ST_WAIT;
            end
        endcase

        // Bus conditions override any transfer in progress
        if (start_c) begin
            d.state   = ST_ADDR;
            d.cnt     = '0;
            d.sda_oen = 1'b1;
        end else if (stop_c) begin
            d.state   = ST_WAIT;
            d.sda_oen = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            q <= SYS_RST;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign scl_o            = 1'b0;
    assign sda_o            = 1'b0;
    assign scl_oe_n_o       = q.scl_oen;
    assign sda_oe_n_o       = q.sda_oen;
    assign meas_start_o     = q.start_p;
    assign meas_low_power_o = q.lp;
    assign calib_reload_o   = q.reload_p;
    assign idle_o           = (q.phase == PH_IDLE);
    assign measuring_o      = (q.phase == PH_MEAS);

endmodule : sis_top
`default_nettype wire

// ===== verilog/sis_pkg.sv
`default_nettype none
package sis_pkg;

    // ************************************************************
    // Bus identity and command codes
    // ************************************************************
    localparam logic [7:0]  SIS_HDR_ADDR  = 8'h60;  // Header byte with R/W bit low
    localparam logic [15:0] SIS_CMD_SRST  = 16'h805d;
    localparam logic [15:0] SIS_CMD_N_CS_T  = 16'h7ca2;
    localparam logic [15:0] SIS_CMD_N_CS_RH = 16'h5c24;
    localparam logic [15:0] SIS_CMD_N_T     = 16'h7866;
    localparam logic [15:0] SIS_CMD_N_RH    = 16'h58e0;
    localparam logic [15:0] SIS_CMD_L_CS_T  = 16'h6458;
    localparam logic [15:0] SIS_CMD_L_CS_RH = 16'h44de;
    localparam logic [15:0] SIS_CMD_L_T     = 16'h609c;
    localparam logic [15:0] SIS_CMD_L_RH    = 16'h401a;
    localparam logic [7:0]  SIS_CRC_POLY  = 8'h31;
    localparam logic [7:0]  SIS_CRC_INIT  = 8'hff;
    localparam logic [2:0]  SIS_LAST_BYTE = 3'h5;   // Two words plus a checksum each

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int SIS_CLK_PERIOD_NS = 25;
    localparam int SIS_PU_MAX_NS     = 240000;
    localparam int SIS_SR_MAX_NS     = 240000;
    localparam int SIS_MEAS_N_MAX_NS = 12100000;
    localparam int SIS_MEAS_L_MAX_NS = 800000;
    // Longest times round down
    localparam int SIS_PU_CYC     = SIS_PU_MAX_NS / SIS_CLK_PERIOD_NS;
    localparam int SIS_SR_CYC     = SIS_SR_MAX_NS / SIS_CLK_PERIOD_NS;
    localparam int SIS_MEAS_N_CYC = SIS_MEAS_N_MAX_NS / SIS_CLK_PERIOD_NS;
    localparam int SIS_MEAS_L_CYC = SIS_MEAS_L_MAX_NS / SIS_CLK_PERIOD_NS;
    localparam int SIS_TMR_W      = 20;

    // ************************************************************
    // States
    // ************************************************************
    typedef enum logic [3:0] {
        ST_WAIT    = 4'h0,
        ST_ADDR    = 4'h1,
        ST_AACK    = 4'h3,
        ST_TX      = 4'h2,
        ST_TACK    = 4'h6,
        ST_TNEXT   = 4'h7,
        ST_WRX     = 4'h5,
        ST_WACK    = 4'h4,
        ST_STRETCH = 4'hc
    } sis_state_type;

    typedef enum logic [1:0] {
        PH_BOOT  = 2'h0,
        PH_IDLE  = 2'h1,
        PH_MEAS  = 2'h3,
        PH_RESET = 2'h2
    } sis_phase_type;

endpackage : sis_pkg
`default_nettype wire

// ===== verif/sis_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sis_top_asserts #(
    parameter int PU_CYC     = 9600,
    parameter int SR_CYC     = 9600,
    parameter int MEAS_N_CYC = 484000,
    parameter int MEAS_L_CYC = 32000
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic scl_o,
    input wire logic scl_oe_n_o,
    input wire logic sda_o,
    input wire logic meas_start_o,
    input wire logic meas_low_power_o,
    input wire logic calib_reload_o,
    input wire logic idle_o,
    input wire logic measuring_o
);
    // ****************
    // Span counters
    // ****************
    logic [31:0] low_cnt_q;
    logic [31:0] meas_cnt_q;
    logic        boot_q;
    logic        srst_q;
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_cnt_q  <= '0;
            meas_cnt_q <= '0;
            boot_q     <= 1'b1;
            srst_q     <= 1'b0;
        end else begin
            low_cnt_q  <= idle_o ? '0 : low_cnt_q + 1;
            meas_cnt_q <= measuring_o ? meas_cnt_q + 1 : '0;
            boot_q     <= boot_q & ~idle_o;
            // Pulse lands in the same cycle that idle first goes low
            srst_q     <= calib_reload_o | (srst_q & ~idle_o);
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    AST_PU_TIME: assert property ($rose(idle_o) && boot_q |-> low_cnt_q inside {[PU_CYC-1:PU_CYC+1]})
        else $error("power-up span out of window");
    AST_SR_TIME: assert property ($rose(idle_o) && srst_q |-> low_cnt_q inside {[SR_CYC-1:SR_CYC+1]})
        else $error("soft reset span out of window");
    AST_MEAS_TIME: assert property ($fell(measuring_o) |-> meas_cnt_q == (meas_low_power_o ? MEAS_L_CYC : MEAS_N_CYC))
        else $error("measurement length wrong");
    AST_MEAS_RUN: assert property (meas_start_o |-> ##[0:1] measuring_o [*7])
        else $error("measurement did not start");
    AST_CMD_IDLE: assert property (meas_start_o || calib_reload_o |-> $past(idle_o))
        else $error("command acted while not idle");
    AST_SRST_HOLD: assert property (calib_reload_o |=> (!idle_o && !measuring_o) [*4])
        else $error("soft reset did not leave idle");
    AST_STR_HOLD: assert property (!scl_oe_n_o |-> measuring_o || $past(measuring_o) || $past(measuring_o, 2))
        else $error("clock held low outside a measurement");
    AST_STR_REL: assert property ($fell(measuring_o) |-> ##[0:2] scl_oe_n_o)
        else $error("clock not released after measurement");
    AST_OPEN_DRAIN: assert property (!scl_o && !sda_o)
        else $error("pin data not low");
    cover property (meas_start_o && meas_low_power_o);
    cover property (!scl_oe_n_o);
    cover property (calib_reload_o);
endmodule : sis_top_asserts
bind sis_top sis_top_asserts #(.PU_CYC(PU_CYC), .SR_CYC(SR_CYC), .MEAS_N_CYC(MEAS_N_CYC),
    .MEAS_L_CYC(MEAS_L_CYC)) sis_top_asserts_inst (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_o(sda_o), .meas_start_o(meas_start_o),
    .meas_low_power_o(meas_low_power_o), .calib_reload_o(calib_reload_o), .idle_o(idle_o),
    .measuring_o(measuring_o));
`default_nettype wire

// ===== verif/sis_mstr.sv
`timescale 1ns/1ps
`default_nettype none
module sis_mstr (
    input  wire logic dev_scl_oe_n_i,
    input  wire logic dev_sda_oe_n_i,
    output logic      scl_o,
    output logic      sda_o
);
    // ****************
    // Bus master model
    // ****************
    localparam int HALF = 500;
    logic m_scl_q    = 1'b1;
    logic m_sda_q    = 1'b1;
    int   stretch_ns = 0;
    // Pull-ups make the high level; nobody drives high
    assign scl_o = m_scl_q & dev_scl_oe_n_i;
    assign sda_o = m_sda_q & dev_sda_oe_n_i;
    task automatic bit_x(input logic b, output logic r);
        int n;
        n = 0;
        // Late SDA change keeps the synchronisers from seeing a false start
        #100 m_sda_q = b;
        #(HALF - 100) m_scl_q = 1'b1;
        #1;
        while (scl_o !== 1'b1 && n < 40000) begin
            #25 n++;
        end
        stretch_ns += n * 25;
        #HALF r = sda_o;
        m_scl_q = 1'b0;
    endtask : bit_x
    task automatic start();
        m_sda_q = 1'b1;
        m_scl_q = 1'b1;
        #HALF m_sda_q = 1'b0;
        #HALF m_scl_q = 1'b0;
    endtask : start
    task automatic stop();
        #100 m_sda_q = 1'b0;
        #(HALF - 100) m_scl_q = 1'b1;
        #HALF m_sda_q = 1'b1;
        #HALF;
    endtask : stop
    task automatic wr(input logic [7:0] d, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        a = (r === 1'b0);
    endtask : wr
    task automatic rd(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(last, r);
    endtask : rd
endmodule : sis_mstr
`default_nettype wire

// ===== verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sis_pkg::*;
    localparam int PU = 800;
    localparam int SR = 800;
    localparam int MN = 2400;
    localparam int ML = 800;
    logic        clk_sys;
    logic        resetn;
    logic [15:0] temp_data;
    logic [15:0] hum_data;
    wire logic   scl_w, sda_w, scl_oe_n, sda_oe_n;
    wire logic   meas_start, low_pw, calib, idle, measuring;
    int          miscompares = 0;
    int          n_tests     = 0;
    int          n_calib     = 0;
    logic [18:0] rows [8] = '{{SIS_CMD_N_CS_T, 3'b010}, {SIS_CMD_N_CS_RH, 3'b011},
        {SIS_CMD_N_T, 3'b000}, {SIS_CMD_N_RH, 3'b001}, {SIS_CMD_L_CS_T, 3'b110},
        {SIS_CMD_L_CS_RH, 3'b111}, {SIS_CMD_L_T, 3'b100}, {SIS_CMD_L_RH, 3'b101}};
    logic [7:0]  bad_hdr [4] = '{8'h62, 8'he0, 8'h20, 8'h70};
    sis_top #(.PU_CYC(PU), .SR_CYC(SR), .MEAS_N_CYC(MN), .MEAS_L_CYC(ML)) sis_top_inst (
        .clk_sys_i(clk_sys), .resetn_i(resetn), .scl_clk_i(scl_w), .scl_i(scl_w),
        .sda_i(sda_w), .scl_o(), .scl_oe_n_o(scl_oe_n), .sda_o(), .sda_oe_n_o(sda_oe_n),
        .temp_data_i(temp_data), .hum_data_i(hum_data), .meas_start_o(meas_start),
        .meas_low_power_o(low_pw), .calib_reload_o(calib), .idle_o(idle),
        .measuring_o(measuring));
    sis_mstr sis_mstr_inst (.dev_scl_oe_n_i(scl_oe_n), .dev_sda_oe_n_i(sda_oe_n),
        .scl_o(scl_w), .sda_o(sda_w));
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (calib === 1'b1) n_calib++;
    function automatic logic [7:0] crc8(input logic [15:0] w);
        logic [7:0] c;
        c = SIS_CRC_INIT;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? SIS_CRC_POLY : 8'h00);
        return c;
    endfunction : crc8
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick();
        @(posedge clk_sys);
        #2;
    endtask : tick
    task automatic wait_ready();
        int n;
        n = 0;
        while (idle !== 1'b1 && n < 10000) begin
            @(posedge clk_sys);
            n++;
        end
        chk(16'(n < 10000), 16'h1);
    endtask : wait_ready
    task automatic hdr(input logic [7:0] h, input logic exp);
        logic a;
        sis_mstr_inst.start();
        sis_mstr_inst.wr(h, a);
        sis_mstr_inst.stop();
        chk(16'(a), 16'(exp));
    endtask : hdr
    task automatic cmd(input logic [15:0] c);
        logic a0, a1, a2;
        sis_mstr_inst.start();
        sis_mstr_inst.wr(SIS_HDR_ADDR, a0);
        sis_mstr_inst.wr(c[15:8], a1);
        sis_mstr_inst.wr(c[7:0], a2);
        sis_mstr_inst.stop();
        chk({13'h0, a0, a1, a2}, 16'h7);
    endtask : cmd
    task automatic rd6(input logic [15:0] w0, input logic [15:0] w1);
        logic       a;
        logic [7:0] d [6];
        sis_mstr_inst.start();
        sis_mstr_inst.wr(SIS_HDR_ADDR | 8'h01, a);
        for (int i = 0; i < 6; i++) sis_mstr_inst.rd(i == 5, d[i]);
        sis_mstr_inst.stop();
        chk(16'(a), 16'h1);
        chk({d[0], d[1], d[3], d[4]} >> 16, w0);
        chk({d[3], d[4]}, w1);
        chk({d[2], d[5]}, {crc8(w0), crc8(w1)});
    endtask : rd6
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        #5ms;
        miscompares++;
        print_verdict();
    end
    initial begin
        clk_sys   = 1'b0;
        resetn    = 1'b0;
        temp_data = 16'h0;
        hum_data  = 16'h0;
        repeat (2) tick();
        resetn = 1'b1;
        wait_ready();
        foreach (rows[i]) begin
            tick();
            temp_data = 16'h3c10 + 16'(i);
            hum_data = 16'ha5e0 - 16'(i * 3);
            sis_mstr_inst.stretch_ns = 0;
            cmd(rows[i][18:3]);
            chk(16'(low_pw), 16'(rows[i][2]));
            if (!rows[i][1]) wait_ready();
            if (rows[i][0]) rd6(hum_data, temp_data);
            else rd6(temp_data, hum_data);
            chk(16'(sis_mstr_inst.stretch_ns > 0), 16'(rows[i][1]));
        end
        // Foreign addresses stay unanswered
        foreach (bad_hdr[i]) hdr(bad_hdr[i], 1'b0);
        cmd(SIS_CMD_N_T);
        hdr(SIS_HDR_ADDR | 8'h01, 1'b0);
        hdr(SIS_HDR_ADDR, 1'b0);
        chk(16'(n_calib), 16'h0);
        wait_ready();
        cmd(SIS_CMD_SRST);
        chk(16'(n_calib), 16'h1);
        hdr(SIS_HDR_ADDR, 1'b0);
        wait_ready();
        hdr(SIS_HDR_ADDR, 1'b1);
        // Power loss in the middle of a measurement
        cmd(SIS_CMD_L_CS_T);
        tick();
        resetn = 1'b0;
        repeat (2) tick();
        resetn = 1'b1;
        chk({14'h0, measuring, idle}, 16'h0);
        hdr(SIS_HDR_ADDR, 1'b0);
        wait_ready();
        hdr(SIS_HDR_ADDR, 1'b1);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
